// ==== sscs_afe_model.sv ====
// Analog side model: sample-and-hold and comparator for the search word.
// Assumes the bench gives each channel's input as an 18-bit code.
`timescale 1ns/1ps
`default_nettype none
module sscs_afe_model
  import sscs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic holdSample,
  input wire logic [RES_BITS-1:0] searchDac,
  input wire logic [CH_BITS-1:0] muxChannel,
  input wire logic [7:0][RES_BITS-1:0] level,
  output logic compAbove
);
  logic held_q = 1'h0;
  logic noise_q = 1'h0;
  logic [RES_BITS-1:0] sample_q;
  always_ff @(posedge ref_clk)
  begin
    held_q <= holdSample;
    noise_q <= ~noise_q;
    if (holdSample && !held_q)
      sample_q <= level[muxChannel];
  end
  // trial comparison; toggles when not holding
  assign compAbove = holdSample ? (sample_q >= searchDac) : noise_q;
endmodule
`default_nettype wire

// ==== sscs_pkg.sv ====
// Shared constants, types and register map of the conversion and span control block.
// Assumes a single 50 MHz clock domain; the analog comparator and search DAC sit outside.
package sscs_pkg;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int RES_BITS = 18;
  localparam int CH_BITS = 3;
  localparam int SPAN_BITS = 3;
  localparam int SEQ_DEPTH = 8;
  localparam int SEQ_PTR_BITS = 3;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 32;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HOLD_SETTLE_NS = 60;
  localparam int DAC_SETTLE_NS = 40;
  // Least times round up to whole cycles
  localparam int HOLD_CYCLES = (HOLD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DAC_CYCLES = (DAC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_BITS = 4;

  // ----------------------------------------
  // Register map (word indices)
  // ----------------------------------------
  localparam logic [ADDR_BITS-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_BITS-1:0] ADDR_STATUS = 4'h1;
  localparam logic [ADDR_BITS-1:0] ADDR_RESULT = 4'h2;
  localparam logic [ADDR_BITS-1:0] ADDR_SEQ_BASE = 4'h8;

  // Control fields
  localparam int CTRL_SEQ_EN_BIT = 0;
  localparam int CTRL_SEQ_LAST_LSB = 4;
  localparam int CTRL_CH_LSB = 8;
  localparam int CTRL_SPAN_LSB = 12;
  localparam logic [DATA_BITS-1:0] CTRL_RESET = 32'h0000_0000;
  // Sequencer entry fields
  localparam int SEQ_CH_LSB = 0;
  localparam int SEQ_SPAN_LSB = 4;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LVDS_BIT = 1;
  localparam int ST_NAP_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_PTR_LSB = 4;
  localparam int ST_NEW_BIT = 8;
  // Result fields
  localparam int RES_CH_LSB = 20;
  localparam int RES_SPAN_LSB = 24;
  localparam int RES_BIP_BIT = 28;

  // Bit of the span code that marks a bipolar span
  localparam int SPAN_BIPOLAR_BIT = 1;

  // Pin indices in the synchroniser bank
  localparam int PIN_CNV = 0;
  localparam int PIN_LVDS = 1;
  localparam int PIN_NAP = 2;
  localparam int PIN_PD = 3;
  localparam int PIN_COUNT = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_TRACK = 5'b00001,
    ST_HOLD = 5'b00010,
    ST_TRIAL = 5'b00100,
    ST_DECIDE = 5'b01000,
    ST_DONE = 5'b10000
  } sscs_state_e;

  typedef struct packed {
    logic [CH_BITS-1:0] channel;
    logic [SPAN_BITS-1:0] span;
  } sscs_conv_s;

  typedef struct packed {
    logic [RES_BITS-1:0] code;
    logic [CH_BITS-1:0] channel;
    logic [SPAN_BITS-1:0] span;
    logic bipolar;
  } sscs_result_s;

endpackage

// ==== sscs_span_control.sv ====
// Conversion control, successive-approximation search and result coding for an
// eight-channel converter. Pins come from outside the clock domain; the comparator
// answer is expected to be valid DAC settle time after the search DAC word changes.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sscs_span_control
  import sscs_pkg::*;
#(
  parameter int SETTLE_CYCLES = DAC_CYCLES,
  parameter int HOLD_WAIT = HOLD_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic convStartPin,
  input wire logic lvdsSelPin,
  input wire logic napPin,
  input wire logic powerDownPin,
  input wire logic compAbove,
  input wire logic [ADDR_BITS-1:0] regAddr,
  input wire logic [DATA_BITS-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_BITS-1:0] regRdData,
  output logic holdSample,
  output logic [RES_BITS-1:0] searchDac,
  output logic [CH_BITS-1:0] muxChannel,
  output logic [SPAN_BITS-1:0] muxSpan,
  output logic analogOn,
  output logic napActive,
  output logic linkLvds,
  output logic busy,
  output logic resultValid,
  output sscs_result_s result
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Span polarity decode
  // bipolar span codes
  function automatic logic spanIsBipolar(input logic [SPAN_BITS-1:0] span);
    spanIsBipolar = span[SPAN_BIPOLAR_BIT];
  endfunction

  // Word address match
  function automatic logic addrHit(input logic [ADDR_BITS-1:0] a, input logic [ADDR_BITS-1:0] b);
    addrHit = (a == b);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] syncA_q;
  logic [PIN_COUNT-1:0] syncB_q;
  logic [PIN_COUNT-1:0] syncC_q;
  logic [PIN_COUNT-1:0] pinLevel_q;
  logic [PIN_COUNT-1:0] pinLevel_d;

  assign pinRaw[PIN_CNV] = convStartPin;
  assign pinRaw[PIN_LVDS] = lvdsSelPin;
  assign pinRaw[PIN_NAP] = napPin;
  assign pinRaw[PIN_PD] = powerDownPin;

  // Level changes only once the second and third stages agree
  genvar gp;
  generate
    for (gp = 0; gp < PIN_COUNT; gp++)
    begin : g_pin
      assign pinLevel_d[gp] = (syncB_q[gp] == syncC_q[gp]) ? syncC_q[gp] : pinLevel_q[gp];
    end
  endgenerate

  // Three-stage capture of the pins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      pinLevel_q <= '0;
    end
    else if (clkEn)
    begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      pinLevel_q <= pinLevel_d;
    end
  end

  // ----------------------------------------
  // Registers and sequencer table
  // ----------------------------------------
  logic [DATA_BITS-1:0] ctrl_q;
  logic [DATA_BITS-1:0] ctrl_d;
  logic [SPAN_BITS+CH_BITS+1:0] seqTable_q [SEQ_DEPTH];
  logic [SEQ_PTR_BITS-1:0] seqPtr_q;
  logic [SEQ_PTR_BITS-1:0] seqPtr_d;
  logic resultNew_q;
  logic resultNew_d;
  logic [DATA_BITS-1:0] rdData_d;
  logic [DATA_BITS-1:0] statusWord;
  logic [DATA_BITS-1:0] resultWord;
  logic [DATA_BITS-1:0] seqWord;
  logic wrCtrl;
  logic seqSel;
  logic wrSeq;
  logic rdResult;
  logic seqEnable;
  logic [SEQ_PTR_BITS-1:0] seqLast;
  logic [SEQ_PTR_BITS-1:0] seqIdx;

  assign wrCtrl = regWr && addrHit(regAddr, ADDR_CTRL);
  assign seqSel = regAddr[ADDR_BITS-1] == ADDR_SEQ_BASE[ADDR_BITS-1];
  assign seqIdx = regAddr[SEQ_PTR_BITS-1:0];
  assign wrSeq = regWr && seqSel;
  assign rdResult = regRd && addrHit(regAddr, ADDR_RESULT);
  assign ctrl_d = wrCtrl ? regWrData : ctrl_q;
  assign seqEnable = ctrl_q[CTRL_SEQ_EN_BIT];
  assign seqLast = ctrl_q[CTRL_SEQ_LAST_LSB +: SEQ_PTR_BITS];

  // ----------------------------------------
  // Conversion sequencer state
  // ----------------------------------------
  sscs_state_e state_q;
  sscs_state_e state_d;
  logic [WAIT_BITS-1:0] wait_q;
  logic [WAIT_BITS-1:0] wait_d;
  logic [RES_BITS-1:0] sar_q;
  logic [RES_BITS-1:0] sar_d;
  logic [RES_BITS-1:0] trialBit_q;
  logic [RES_BITS-1:0] trialBit_d;
  sscs_conv_s conv_q;
  sscs_conv_s conv_d;
  sscs_conv_s nextConv;
  sscs_result_s result_d;
  logic cnvLevelDly_q;
  logic startEdge;
  logic startTaken;
  logic waitDone;
  logic lastBit;
  logic powerDown;
  logic [SEQ_PTR_BITS+CH_BITS+1:0] seqEntry;

  assign powerDown = pinLevel_q[PIN_PD];
  assign startEdge = pinLevel_q[PIN_CNV] && !cnvLevelDly_q;
  // Starts are ignored while powered down or already converting
  assign startTaken = startEdge && !powerDown && (state_q == ST_TRACK);
  assign waitDone = (wait_q == '0);
  assign lastBit = trialBit_q[0];

  // Channel and span for the conversion about to start
  // span chosen per conversion
  assign seqEntry = seqTable_q[seqPtr_q];
  assign nextConv.channel = seqEnable ? seqEntry[SEQ_CH_LSB +: CH_BITS] : ctrl_q[CTRL_CH_LSB +: CH_BITS];
  assign nextConv.span = seqEnable ? seqEntry[SEQ_SPAN_LSB +: SPAN_BITS] : ctrl_q[CTRL_SPAN_LSB +: SPAN_BITS];

  // step pointer each conversion, wrap after last entry
  assign seqPtr_d = !seqEnable ? '0 :
                    !startTaken ? seqPtr_q :
                    (seqPtr_q >= seqLast) ? '0 : seqPtr_q + 1'b1;

  // Next-state logic of the conversion engine
  always_comb
  begin
    state_d = state_q;
    wait_d = waitDone ? wait_q : wait_q - 1'b1;
    sar_d = sar_q;
    trialBit_d = trialBit_q;
    conv_d = conv_q;
    unique case (state_q)
      ST_TRACK:
      begin
        if (startTaken)
        begin
          state_d = ST_HOLD;
          conv_d = nextConv;
          sar_d = '0;
          trialBit_d = '0;
          wait_d = WAIT_BITS'(HOLD_WAIT);
        end
      end
      ST_HOLD:
      begin
        if (waitDone)
        begin
          state_d = ST_TRIAL;
          trialBit_d = {1'b1, {(RES_BITS-1){1'b0}}};
          sar_d = {1'b1, {(RES_BITS-1){1'b0}}};
          wait_d = WAIT_BITS'(SETTLE_CYCLES);
        end
      end
      ST_TRIAL:
      begin
        if (waitDone)
        begin
          state_d = ST_DECIDE;
        end
      end
      ST_DECIDE:
      begin
        // keep or drop the trial bit, then halve the weight
        sar_d = compAbove ? sar_q : (sar_q & ~trialBit_q);
        if (lastBit)
        begin
          state_d = ST_DONE;
        end
        else
        begin
          trialBit_d = trialBit_q >> 1;
          sar_d = (compAbove ? sar_q : (sar_q & ~trialBit_q)) | (trialBit_q >> 1);
          wait_d = WAIT_BITS'(SETTLE_CYCLES);
          state_d = ST_TRIAL;
        end
      end
      ST_DONE:
      begin
        // back to tracking for the next sample
        state_d = ST_TRACK;
      end
      default:
      begin
        state_d = ST_TRACK;
      end
    endcase
  end

  // Result coding: the search gives offset binary
  // 18-bit result code
  // bipolar flips MSB to two's complement
  assign result_d.code = spanIsBipolar(conv_q.span) ? (sar_q ^ {1'b1, {(RES_BITS-1){1'b0}}}) : sar_q;
  assign result_d.channel = conv_q.channel;
  assign result_d.span = conv_q.span;
  assign result_d.bipolar = spanIsBipolar(conv_q.span);

  // New-result flag: a finishing conversion wins over a clearing read
  assign resultNew_d = (state_q == ST_DONE) ? 1'b1 : (rdResult ? 1'b0 : resultNew_q);

  // ----------------------------------------
  // Read data decode
  // ----------------------------------------
  assign statusWord = {{(DATA_BITS-ST_NEW_BIT-1){1'b0}}, resultNew_q,
                       {(ST_NEW_BIT-ST_PTR_LSB-SEQ_PTR_BITS){1'b0}}, seqPtr_q,
                       powerDown, pinLevel_q[PIN_NAP], pinLevel_q[PIN_LVDS], busy};
  assign resultWord = {{(DATA_BITS-RES_BIP_BIT-1){1'b0}}, result.bipolar,
                       1'b0, result.span, 1'b0, result.channel,
                       {(RES_CH_LSB-RES_BITS){1'b0}}, result.code};
  assign seqWord = DATA_BITS'(seqTable_q[seqIdx]);
  assign rdData_d = !regRd ? '0 :
                    addrHit(regAddr, ADDR_CTRL) ? ctrl_q :
                    addrHit(regAddr, ADDR_STATUS) ? statusWord :
                    addrHit(regAddr, ADDR_RESULT) ? resultWord :
                    seqSel ? seqWord : '0;

  // ----------------------------------------
  // State registers
  // ----------------------------------------

  // Engine and control registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= ST_TRACK;
      wait_q <= '0;
      sar_q <= '0;
      trialBit_q <= '0;
      conv_q <= '0;
      cnvLevelDly_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      seqPtr_q <= '0;
      resultNew_q <= 1'b0;
      regRdData <= '0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      wait_q <= wait_d;
      sar_q <= sar_d;
      trialBit_q <= trialBit_d;
      conv_q <= conv_d;
      cnvLevelDly_q <= pinLevel_q[PIN_CNV];
      ctrl_q <= ctrl_d;
      seqPtr_q <= seqPtr_d;
      resultNew_q <= resultNew_d;
      regRdData <= rdData_d;
    end
  end

  // Sequencer table, cleared at reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < SEQ_DEPTH; i++)
      begin
        seqTable_q[i] <= '0;
      end
    end
    else if (clkEn && wrSeq)
    begin
      seqTable_q[seqIdx] <= {1'b0, regWrData[SEQ_SPAN_LSB +: SPAN_BITS], 1'b0, regWrData[SEQ_CH_LSB +: CH_BITS]};
    end
  end

  // Output path registers
  // result latched when the search ends
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      result <= '0;
      resultValid <= 1'b0;
      searchDac <= '0;
      muxChannel <= '0;
      muxSpan <= '0;
    end
    else if (clkEn)
    begin
      resultValid <= (state_q == ST_DONE);
      searchDac <= sar_d;
      muxChannel <= conv_d.channel;
      muxSpan <= conv_d.span;
      if (state_q == ST_DONE)
      begin
        result <= result_d;
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // hold while converting
  assign holdSample = (state_q != ST_TRACK);
  assign busy = (state_q != ST_TRACK);
  // link mode follows static select pin
  assign linkLvds = pinLevel_q[PIN_LVDS];
  assign analogOn = !powerDown;
  assign napActive = pinLevel_q[PIN_NAP] && !busy && !powerDown;

endmodule

`default_nettype wire

// ==== sscs_span_control_asserts.sv ====
// Port checks for the conversion and span control block.
// Assumes a bind onto sscs_span_control in one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sscs_span_control_asserts
  import sscs_pkg::*;
#(
  parameter int SETTLE_CYCLES = DAC_CYCLES,
  parameter int HOLD_WAIT = HOLD_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic convStartPin,
  input wire logic holdSample,
  input wire logic [RES_BITS-1:0] searchDac,
  input wire logic [CH_BITS-1:0] muxChannel,
  input wire logic analogOn,
  input wire logic busy,
  input wire logic resultValid,
  input wire sscs_result_s result
);
  // Conversion length window, clock stalls allowed
  localparam int CONV_MIN = 36;
  localparam int CONV_MAX = HOLD_WAIT + 18 * (SETTLE_CYCLES + 2) + 30;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Conversion begins and ends
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_finish;
    $fell(busy) && resultValid;
  endsequence
  property p_startTaken;
    $rose(convStartPin) && !busy && analogOn && clkEn |-> ##[1:6] busy;
  endproperty
  a_startTaken: assert property (p_startTaken)
    else $error("start edge not taken");
  property p_holdBusy;
    busy |-> holdSample;
  endproperty
  a_holdBusy: assert property (p_holdBusy)
    else $error("sample not held during conversion");
  property p_conv;
    s_start |-> ##[CONV_MIN:CONV_MAX] s_finish;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion did not finish in time");
  property p_firstTrial;
    s_start |-> ##[1:8] (searchDac == 18'h20000);
  endproperty
  a_firstTrial: assert property (p_firstTrial)
    else $error("first trial not half scale");
  property p_validPulse;
    resultValid |=> !resultValid && !busy;
  endproperty
  a_validPulse: assert property (p_validPulse)
    else $error("result pulse too long");
  property p_coding;
    resultValid |-> result.bipolar == (result.span inside {3'h7, 3'h6, 3'h3, 3'h2});
  endproperty
  a_coding: assert property (p_coding)
    else $error("bipolar flag wrong for span");
  property p_chanSteady;
    busy && $past(busy) |-> $stable(muxChannel);
  endproperty
  a_chanSteady: assert property (p_chanSteady)
    else $error("channel changed mid conversion");
  property p_pdBlocks;
    s_start |-> analogOn;
  endproperty
  a_pdBlocks: assert property (p_pdBlocks)
    else $error("conversion started while powered down");
endmodule
bind sscs_span_control sscs_span_control_asserts #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .HOLD_WAIT(HOLD_WAIT)
) u_chk (.ref_clk, .reset, .clkEn, .convStartPin, .holdSample, .searchDac,
  .muxChannel, .analogOn, .busy, .resultValid, .result);
`default_nettype wire

// ==== test_sar_conversion_span_control.sv ====
// Bench: register tasks plus pin-driven conversions with expected codes.
// Assumes the analog model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_sar_conversion_span_control
  import sscs_pkg::*;
();
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic clkEn = 1'h1;
  logic convStartPin = 1'h0, lvdsSelPin = 1'h0, napPin = 1'h0, powerDownPin = 1'h0;
  logic [ADDR_BITS-1:0] regAddr = 4'h0;
  logic [DATA_BITS-1:0] regWrData = 32'h0, regRdData, rdWord;
  logic regWr = 1'h0, regRd = 1'h0;
  logic compAbove, holdSample, analogOn, napActive, linkLvds, busy, resultValid;
  logic [RES_BITS-1:0] searchDac, frozen;
  logic [CH_BITS-1:0] muxChannel;
  logic [SPAN_BITS-1:0] muxSpan;
  logic [7:0][RES_BITS-1:0] level;
  sscs_result_s result;
  int badCount = 0, nCompared = 0;
  always #10 ref_clk = ~ref_clk;
  sscs_span_control dut_u (.ref_clk, .reset, .clkEn, .convStartPin, .lvdsSelPin,
    .napPin, .powerDownPin, .compAbove, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .holdSample, .searchDac, .muxChannel, .muxSpan, .analogOn,
    .napActive, .linkLvds, .busy, .resultValid, .result);
  sscs_afe_model u_afe (.ref_clk, .holdSample, .searchDac, .muxChannel, .level, .compAbove);
  // Comparison and closing report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Register bus cycles
  task automatic wr(input logic [ADDR_BITS-1:0] a, input logic [DATA_BITS-1:0] d);
    @(posedge ref_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_BITS-1:0] a);
    @(posedge ref_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1 rdWord = regRdData;
  endtask
  // One conversion; mode 1 stalls the clock, mode 2 retriggers while busy
  task automatic conv(input logic [2:0] ch, input logic [2:0] sp, input int mode);
    logic [RES_BITS-1:0] code;
    logic bip;
    int n;
    n = 0;
    code = level[ch];
    bip = sp inside {3'h7, 3'h6, 3'h3, 3'h2};
    if (bip)
      code[17] = ~code[17];
    @(posedge ref_clk);
    convStartPin <= 1'h1;
    tick(6);
    chk("busy", busy, 1);
    chk("mux channel", muxChannel, ch);
    chk("mux span", muxSpan, sp);
    @(posedge ref_clk);
    convStartPin <= 1'h0;
    tick(20);
    if (mode == 1)
    begin
      @(posedge ref_clk);
      clkEn <= 1'h0;
      tick(2);
      frozen = searchDac;
      tick(8);
      chk("frozen trial", searchDac, frozen);
      @(posedge ref_clk);
      clkEn <= 1'h1;
    end
    if (mode == 2)
    begin
      @(posedge ref_clk);
      convStartPin <= 1'h1;
    end
    while (resultValid !== 1'h1)
    begin
      tick(1);
      n++;
      if (n > 300)
      begin
        badCount++;
        conclude();
      end
    end
    chk("code", result.code, code);
    chk("channel", result.channel, ch);
    chk("span", result.span, sp);
    chk("bipolar", result.bipolar, bip);
    rd(ADDR_STATUS);
    chk("new flag", rdWord[ST_NEW_BIT], 1);
    rd(ADDR_RESULT);
    chk("result word", rdWord, {3'h0, bip, 1'h0, sp, 1'h0, ch, 2'h0, code});
    if (mode == 2)
    begin
      tick(8);
      chk("no retrigger", busy, 0);
      // Low long enough for the pin filter to see it before the next start
      @(posedge ref_clk);
      convStartPin <= 1'h0;
      tick(6);
    end
  endtask
  // ---------------------
  // Main sequence
  // ---------------------
  initial
  begin
    for (int i = 0; i < 8; i++)
      level[i] = 18'(i * 18'h09249);
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    rd(ADDR_CTRL);
    chk("ctrl reset", rdWord, CTRL_RESET);
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3);
    chk("unmapped", rdWord, 32'h0);
    // Every span code, boundary levels at both ends
    for (int s = 0; s < 8; s++)
    begin
      wr(ADDR_CTRL, (32'(s) << CTRL_SPAN_LSB) | (32'(7 - s) << CTRL_CH_LSB));
      conv(3'(7 - s), 3'(s), s == 5 ? 1 : (s == 6 ? 2 : 0));
    end
    level[3] = 18'h0ABCD;
    wr(ADDR_CTRL, 32'h0000_3300);
    conv(3'h3, 3'h3, 0);
    // Sequencer list of three entries, wraps
    wr(ADDR_SEQ_BASE, 32'h0000_0065);
    wr(ADDR_SEQ_BASE + 4'h1, 32'h0000_0012);
    wr(ADDR_SEQ_BASE + 4'h2, 32'h0000_0037);
    wr(ADDR_CTRL, 32'h0000_0021);
    conv(3'h5, 3'h6, 0);
    conv(3'h2, 3'h1, 0);
    conv(3'h7, 3'h3, 0);
    conv(3'h5, 3'h6, 0);
    rd(ADDR_STATUS);
    chk("seq pointer", rdWord[6:4], 3'h1);
    rd(ADDR_SEQ_BASE + 4'h2);
    chk("seq entry", rdWord, 32'h0000_0037);
    wr(ADDR_CTRL, 32'h0);
    // Static pins: nap, link select, power down
    @(posedge ref_clk);
    napPin <= 1'h1;
    lvdsSelPin <= 1'h1;
    tick(6);
    chk("nap", napActive, 1);
    chk("link", linkLvds, 1);
    rd(ADDR_STATUS);
    chk("status", rdWord[3:0], 4'h6);
    @(posedge ref_clk);
    napPin <= 1'h0;
    powerDownPin <= 1'h1;
    tick(6);
    chk("analog off", analogOn, 0);
    chk("nap off", napActive, 0);
    @(posedge ref_clk);
    convStartPin <= 1'h1;
    tick(10);
    chk("start while down", busy, 0);
    @(posedge ref_clk);
    convStartPin <= 1'h0;
    powerDownPin <= 1'h0;
    lvdsSelPin <= 1'h0;
    tick(6);
    chk("analog on", analogOn, 1);
    chk("link spi", linkLvds, 0);
    conclude();
  end
endmodule
`default_nettype wire
